// ===== hdl/erf_framer.sv
`timescale 1ns/100ps
`include "erf_defs.svh"

// Function
// - one response frame per received command
// - result codes: pass 1, fail 2, unknown 3
// - result opcode in header bits 15..12
// - echo command opcode in bits 11..8
// - low byte: query data or error code
// - second word: length including header, one above the words sent for an odd read
// - success gives pass, error gives fail plus reason
// - unrecognised command answers unknown-command result
// - queries always pass with result in byte
// - blank check byte f0 blank, 0f not
// - version byte: main nibble high, revision low
// - successful non-query command error byte zero
// - program verify failure gives error byte one
// - other executive errors give error byte two
// - all responses but read are two words
// - read length three per pair plus two
// - read count up to 32768 instructions
// - odd count: last word upper byte, zero-padded
module erf_framer #(
	parameter int MAX_COUNT = `ERF_MAX_COUNT,
	parameter logic [15:0] KNOWN_MASK = `ERF_KNOWN_MASK
) (
	// Clock and synchronous reset.
	input wire logic clk,
	input wire logic rst,
	// Finished command from the executive core.
	input wire logic req_valid,
	input wire erf_pkg::erf_req_t req,
	output logic req_ready_q,
	// Instructions read from code memory for a read command.
	input wire logic inst_valid,
	input wire logic [23:0] inst_data,
	output logic inst_ready_q,
	// Response words toward the programming link.
	output logic tx_valid_q,
	output logic [15:0] tx_word_q,
	input wire logic tx_ready,
	// Register port.
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata_q,
	// Interrupt request.
	output logic irq_q
);

	// Refuse limits that the 16-bit count and length fields cannot hold.
	initial begin
		if (MAX_COUNT < 1 || MAX_COUNT > `ERF_MAX_COUNT) begin
			$error("erf_framer: MAX_COUNT out of range");
		end
	end

	// Sequence state.
	erf_pkg::erf_state_t state_q;
	// Instructions still to be fetched for a read.
	logic [15:0] rem_q;
	// Frame length, sent as the second word.
	logic [15:0] len_q;
	// Whether the frame carries data words.
	logic data_q;
	// First instruction of the current pair.
	logic [23:0] a_q;
	// Second instruction of the current pair.
	logic [15:0] b_lsw_q;

	// Software control: bit 0 lets commands be accepted.
	logic ctrl_en_q;
	// Executive version byte returned by the version query.
	logic [7:0] version_q;
	// Count of frames completed.
	logic [15:0] frames_q;
	// High byte of the last first header word, kept for status reads.
	logic [7:0] last_q;
	// Sticky interrupt flags and their mask.
	logic [2:0] irq_stat_q;
	logic [2:0] irq_mask_q;

	// One-cycle events from the framer.
	logic ev_frame_q;
	logic ev_fail_q;
	logic ev_unknown_q;

	// Decoded first header word, length and data flag of a request.
	logic [15:0] head_d;
	logic [15:0] len_d;
	logic data_d;
	// Pair count of a read, one bit wider than the count.
	logic [16:0] pairs;
	// Accept of a request in this cycle.
	logic accept;

	assign accept = req_valid && req_ready_q;

	// Decode a finished command into its header fields.
	// The whole first word is built here so that it leaves in one piece.
	always_comb begin
		logic [3:0] res;
		logic [7:0] qe;
		logic known;
		res = `ERF_RES_PASS;
		qe = `ERF_QE_NONE;
		known = KNOWN_MASK[req.cmd];
		pairs = ({1'b0, req.count} + 17'h00001) >> 1;
		len_d = `ERF_HDR_WORDS;
		data_d = 1'b0;
		if (!known) begin
			// Unrecognised opcodes get the unknown result and the other-error code 2.
			res = `ERF_RES_UNKNOWN;
			qe = `ERF_QE_OTHER;
		end else if (req.cmd == `ERF_CMD_BLANK_QUERY) begin
			// Queries pass regardless of the reported outcome.
			res = `ERF_RES_PASS;
			qe = req.blank ? `ERF_QE_BLANK : `ERF_QE_NOT_BLANK;
		end else if (req.cmd == `ERF_CMD_VERSION_QUERY) begin
			res = `ERF_RES_PASS;
			qe = version_q;
		end else if (req.outcome == erf_pkg::ERF_VERIFY_FAIL &&
			(req.cmd == `ERF_CMD_ROW_PROGRAM || req.cmd == `ERF_CMD_SINGLE_ID_PROGRAM)) begin
			// Only the program commands verify, so only they report it.
			res = `ERF_RES_FAIL;
			qe = `ERF_QE_VERIFY;
		end else if (req.outcome != erf_pkg::ERF_OK) begin
			res = `ERF_RES_FAIL;
			qe = `ERF_QE_OTHER;
		end else if (req.cmd == `ERF_CMD_PROGRAM_READ && {16'h0000, req.count} > MAX_COUNT) begin
			// A count beyond the limit is refused as an executive error.
			res = `ERF_RES_FAIL;
			qe = `ERF_QE_OTHER;
		end else begin
			res = `ERF_RES_PASS;
			qe = `ERF_QE_NONE;
			if (req.cmd == `ERF_CMD_PROGRAM_READ && req.count != 16'h0000) begin
				// Each pair takes three words; an odd tail rounds up.
				len_d = 16'((pairs * 17'h00003) + 17'h00002);
				data_d = 1'b1;
			end
		end
		head_d = 16'h0000;
		head_d[`ERF_RES_MSB:`ERF_RES_LSB] = res;
		head_d[`ERF_ECHO_MSB:`ERF_ECHO_LSB] = req.cmd;
		head_d[`ERF_QE_MSB:`ERF_QE_LSB] = qe;
	end

	// Request handshake: ready only while idle and while enabled in the cycle before, so ready lags a disabling write by one cycle.
	// Ready drops in the cycle after an accept, so a second request waits for the frame.
	always_ff @(posedge clk) begin
		if (rst) begin
			req_ready_q <= 1'b0;
		end else begin
			req_ready_q <= ctrl_en_q && (state_q == erf_pkg::S_IDLE) && !accept;
		end
	end

	// Framer sequence and link words.
	// Each emitting state holds its word until the link takes it.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= erf_pkg::S_IDLE;
			tx_valid_q <= 1'b0;
			tx_word_q <= 16'h0000;
			inst_ready_q <= 1'b0;
			rem_q <= 16'h0000;
			len_q <= 16'h0000;
			data_q <= 1'b0;
			a_q <= 24'h000000;
			b_lsw_q <= 16'h0000;
			last_q <= 8'h00;
			ev_frame_q <= 1'b0;
			ev_fail_q <= 1'b0;
			ev_unknown_q <= 1'b0;
		end else begin
			ev_frame_q <= 1'b0;
			ev_fail_q <= 1'b0;
			ev_unknown_q <= 1'b0;
			case (state_q)
				erf_pkg::S_IDLE: begin
					// Load the first header word as soon as a command is taken.
					if (accept) begin
						tx_word_q <= head_d;
						tx_valid_q <= 1'b1;
						len_q <= len_d;
						data_q <= data_d;
						rem_q <= req.count;
						last_q <= head_d[15:8];
						ev_fail_q <= (head_d[15:12] == `ERF_RES_FAIL);
						ev_unknown_q <= (head_d[15:12] == `ERF_RES_UNKNOWN);
						state_q <= erf_pkg::S_HEAD;
					end
				end
				erf_pkg::S_HEAD: begin
					// Length word follows the first header word.
					if (tx_ready) begin
						tx_word_q <= len_q;
						state_q <= erf_pkg::S_LEN;
					end
				end
				erf_pkg::S_LEN: begin
					if (tx_ready) begin
						tx_valid_q <= 1'b0;
						if (data_q) begin
							inst_ready_q <= 1'b1;
							state_q <= erf_pkg::S_GET_A;
						end else begin
							ev_frame_q <= 1'b1;
							state_q <= erf_pkg::S_IDLE;
						end
					end
				end
				erf_pkg::S_GET_A: begin
					// First of a pair: its low word goes straight out.
					if (inst_valid && inst_ready_q) begin
						inst_ready_q <= 1'b0;
						a_q <= inst_data;
						rem_q <= rem_q - 16'h0001;
						tx_word_q <= inst_data[15:0];
						tx_valid_q <= 1'b1;
						state_q <= erf_pkg::S_LSW_A;
					end
				end
				erf_pkg::S_LSW_A: begin
					if (tx_ready) begin
						if (rem_q == 16'h0000) begin
							// Odd tail: upper byte alone, zero in the high byte.
							tx_word_q <= {8'h00, a_q[23:16]};
							state_q <= erf_pkg::S_ODD;
						end else begin
							tx_valid_q <= 1'b0;
							inst_ready_q <= 1'b1;
							state_q <= erf_pkg::S_GET_B;
						end
					end
				end
				erf_pkg::S_GET_B: begin
					// Second of a pair: both upper bytes share one word.
					if (inst_valid && inst_ready_q) begin
						inst_ready_q <= 1'b0;
						b_lsw_q <= inst_data[15:0];
						rem_q <= rem_q - 16'h0001;
						tx_word_q <= {inst_data[23:16], a_q[23:16]};
						tx_valid_q <= 1'b1;
						state_q <= erf_pkg::S_MSB;
					end
				end
				erf_pkg::S_MSB: begin
					if (tx_ready) begin
						tx_word_q <= b_lsw_q;
						state_q <= erf_pkg::S_LSW_B;
					end
				end
				erf_pkg::S_LSW_B: begin
					if (tx_ready) begin
						tx_valid_q <= 1'b0;
						if (rem_q == 16'h0000) begin
							ev_frame_q <= 1'b1;
							state_q <= erf_pkg::S_IDLE;
						end else begin
							inst_ready_q <= 1'b1;
							state_q <= erf_pkg::S_GET_A;
						end
					end
				end
				erf_pkg::S_ODD: begin
					if (tx_ready) begin
						tx_valid_q <= 1'b0;
						ev_frame_q <= 1'b1;
						state_q <= erf_pkg::S_IDLE;
					end
				end
				default: begin
					// Unused encodings fall back to idle with the link quiet.
					tx_valid_q <= 1'b0;
					inst_ready_q <= 1'b0;
					state_q <= erf_pkg::S_IDLE;
				end
			endcase
		end
	end

	// Software-written control and version registers.
	// Clearing enable mid-frame lets the frame finish; only new commands wait.
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_en_q <= 1'(`ERF_RST_CTRL);
			version_q <= `ERF_RST_VERSION;
			irq_mask_q <= `ERF_RST_IRQ_MASK;
		end else if (reg_wr) begin
			case (reg_addr)
				`ERF_REG_CTRL: begin
					ctrl_en_q <= reg_wdata[0];
				end
				`ERF_REG_VERSION: begin
					version_q <= reg_wdata[7:0];
				end
				`ERF_REG_IRQ_MASK: begin
					irq_mask_q <= reg_wdata[2:0];
				end
				default: begin
					// Other offsets are read-only, unmapped, or the write-one-clear flags handled below.
				end
			endcase
		end
	end

	// Completed frame counter, wrapping.
	always_ff @(posedge clk) begin
		if (rst) begin
			frames_q <= 16'h0000;
		end else if (ev_frame_q) begin
			frames_q <= frames_q + 16'h0001;
		end
	end

	// Write-one-clear bits and event bits of the sticky flags.
	logic [2:0] irq_clr;
	logic [2:0] irq_set;

	// Clear bits only count on a write to the status offset.
	always_comb begin
		irq_clr = (reg_wr && reg_addr == `ERF_REG_IRQ_STAT) ? reg_wdata[2:0] : 3'h0;
		irq_set = 3'h0;
		irq_set[`ERF_IRQ_FRAME] = ev_frame_q;
		irq_set[`ERF_IRQ_FAIL] = ev_fail_q;
		irq_set[`ERF_IRQ_UNKNOWN] = ev_unknown_q;
	end

	// Sticky interrupt flags, cleared by writing one.
	// A new event in the clearing cycle still sets its flag.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat_q <= 3'h0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
		end
	end

	// Level interrupt, one cycle behind the flags.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Read data stand only in the cycle after the read strobe.
	// Unmapped offsets read as zero.
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`ERF_REG_CTRL: begin
					reg_rdata_q <= {15'h0000, ctrl_en_q};
				end
				`ERF_REG_VERSION: begin
					reg_rdata_q <= {8'h00, version_q};
				end
				`ERF_REG_STATUS: begin
					reg_rdata_q <= {last_q, 6'h00, req_ready_q, (state_q != erf_pkg::S_IDLE)};
				end
				`ERF_REG_FRAMES: begin
					reg_rdata_q <= frames_q;
				end
				`ERF_REG_IRQ_STAT: begin
					reg_rdata_q <= {13'h0000, irq_stat_q};
				end
				`ERF_REG_IRQ_MASK: begin
					reg_rdata_q <= {13'h0000, irq_mask_q};
				end
				default: begin
					reg_rdata_q <= 16'h0000;
				end
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end

endmodule

// ===== hdl/erf_defs.svh
`ifndef ERF_DEFS_SVH
`define ERF_DEFS_SVH

// Register offsets on the plain register port.
`define ERF_REG_CTRL 4'h0
`define ERF_REG_VERSION 4'h1
`define ERF_REG_STATUS 4'h2
`define ERF_REG_FRAMES 4'h3
`define ERF_REG_IRQ_STAT 4'h4
`define ERF_REG_IRQ_MASK 4'h5

// Reset values; the version value is arbitrary.
`define ERF_RST_CTRL 16'h0001
`define ERF_RST_VERSION 8'h10
`define ERF_RST_IRQ_MASK 3'h0

// Field positions of the first header word.
`define ERF_RES_MSB 15
`define ERF_RES_LSB 12
`define ERF_ECHO_MSB 11
`define ERF_ECHO_LSB 8
`define ERF_QE_MSB 7
`define ERF_QE_LSB 0

// Response opcodes.
`define ERF_RES_PASS 4'h1
`define ERF_RES_FAIL 4'h2
`define ERF_RES_UNKNOWN 4'h3

// Query or error byte values.
`define ERF_QE_NONE 8'h00
`define ERF_QE_VERIFY 8'h01
`define ERF_QE_OTHER 8'h02
`define ERF_QE_BLANK 8'hf0
`define ERF_QE_NOT_BLANK 8'h0f

// Command opcodes that change the frame.
`define ERF_CMD_PROGRAM_READ 4'h2
`define ERF_CMD_SINGLE_ID_PROGRAM 4'h4
`define ERF_CMD_ROW_PROGRAM 4'h5
`define ERF_CMD_BLANK_QUERY 4'ha
`define ERF_CMD_VERSION_QUERY 4'hb

// One bit per recognised command opcode.
`define ERF_KNOWN_MASK 16'h2c36

// Header length in words and the read count limit.
`define ERF_HDR_WORDS 16'h0002
`define ERF_MAX_COUNT 32768

// Interrupt bit positions.
`define ERF_IRQ_FRAME 0
`define ERF_IRQ_FAIL 1
`define ERF_IRQ_UNKNOWN 2

`endif

// ===== hdl/erf_pkg.sv
package erf_pkg;

	// Outcome that the executive core reports with a finished command.
	typedef enum logic [1:0] {
		ERF_OK,
		ERF_VERIFY_FAIL,
		ERF_OTHER_FAIL
	} erf_outcome_t;

	// One finished command, handed over for framing.
	typedef struct packed {
		logic [3:0] cmd;
		erf_outcome_t outcome;
		logic blank;
		logic [15:0] count;
	} erf_req_t;

	// Framer sequence states.
	typedef enum logic [3:0] {
		S_IDLE,
		S_HEAD,
		S_LEN,
		S_GET_A,
		S_LSW_A,
		S_GET_B,
		S_MSB,
		S_LSW_B,
		S_ODD
	} erf_state_t;

endpackage

// ===== verif/erf_framer_asserts.sv
`timescale 1ns/100ps

// Checks the framer's request, link and register read ports.
module erf_framer_chk #(
	parameter int MAX_COUNT = 32768,
	parameter logic [15:0] KNOWN_MASK = 16'h2c36
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Request side.
	input wire logic req_valid,
	input wire erf_pkg::erf_req_t req,
	input wire logic req_ready_q,
	// Link side.
	input wire logic tx_valid_q,
	input wire logic [15:0] tx_word_q,
	input wire logic tx_ready,
	// Register read port.
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata_q
);
	// A request is taken at this edge.
	wire acc = req_valid && req_ready_q;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_header_follows: assert property (acc |=> tx_valid_q && !req_ready_q)
		else $error("no header after accept");
	chk_echo_cmd: assert property (acc |=> tx_word_q[11:8] == $past(req.cmd))
		else $error("command not echoed");
	chk_unknown_cmd: assert property (acc && !KNOWN_MASK[req.cmd]
		|=> tx_word_q == {4'h3, $past(req.cmd), 8'h02})
		else $error("unknown command header wrong");
	chk_query_pass: assert property (acc && req.cmd inside {4'ha, 4'hb} |=> tx_word_q[15:12] == 4'h1)
		else $error("query did not pass");
	chk_blank_byte: assert property (acc && req.cmd == 4'ha
		|=> tx_word_q[7:0] == ($past(req.blank) ? 8'hf0 : 8'h0f))
		else $error("blank check byte wrong");
	chk_verify_code: assert property (acc && req.cmd inside {4'h4, 4'h5}
		&& req.outcome == erf_pkg::ERF_VERIFY_FAIL
		|=> tx_word_q[15:12] == 4'h2 && tx_word_q[7:0] == 8'h01) else $error("verify failure code wrong");
	chk_plain_pass: assert property (acc && KNOWN_MASK[req.cmd] && req.outcome == erf_pkg::ERF_OK
		&& !(req.cmd inside {4'h2, 4'ha, 4'hb}) |=> tx_word_q[15:12] == 4'h1 && tx_word_q[7:0] == 8'h00)
		else $error("success header wrong");
	chk_short_length: assert property (acc && req.cmd != 4'h2 ##1 tx_ready
		|=> tx_valid_q && tx_word_q == 16'h0002)
		else $error("short length word wrong");
	chk_word_held: assert property (tx_valid_q && !tx_ready |=> tx_valid_q && $stable(tx_word_q))
		else $error("word changed before taken");
	chk_read_idle: assert property (!reg_rd |=> reg_rdata_q == 16'h0000)
		else $error("read data outside read cycle");
endmodule

bind erf_framer erf_framer_chk #(.MAX_COUNT(MAX_COUNT), .KNOWN_MASK(KNOWN_MASK)) erf_framer_chk_inst (
	.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q),
	.tx_valid_q(tx_valid_q), .tx_word_q(tx_word_q), .tx_ready(tx_ready),
	.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

// ===== verif/erf_link_model.sv
`timescale 1ns/100ps

// Programmer side of the link: takes response words, stalling when slow.
module erf_link_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Stall each offered word for one cycle when set.
	input wire logic slow,
	// Offered response word.
	input wire logic tx_valid_q,
	output logic tx_ready
);
	// Phase advances only while a word is offered, so each word sees a stall.
	logic ph_q;
	always_ff @(posedge clk) begin
		ph_q <= rst ? 1'b0 : ph_q ^ tx_valid_q;
	end
	// A word is taken only at an edge where valid and ready are both high.
	assign tx_ready = !slow || ph_q;
endmodule

// ===== verif/erf_framer_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH %0t got %h exp %h", $time, g, e); end end

module erf_framer_bench;
	// Stimulus into the framer.
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	erf_pkg::erf_req_t req = '0;
	logic inst_valid = 1'b0;
	logic [23:0] inst_data = 24'h113c00;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic slow = 1'b0;
	// Framer and link outputs.
	logic req_ready_q, inst_ready_q, tx_valid_q, tx_ready, irq_q;
	logic [15:0] tx_word_q, reg_rdata_q;
	// Taken words, instructions handed out, rows and counters.
	logic [15:0] q [$];
	int kk = 0;
	int n_fail = 0;
	int checks_done = 0;
	logic [38:0] rows [16];

	always #50 clk = !clk;

	// Instruction k of the code memory; every byte differs from its neighbours.
	function automatic logic [23:0] inst_of(int k);
		return {k[7:0] + 8'h11, 8'h3c, k[7:0]};
	endfunction

	erf_framer erf_framer_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ready_q(req_ready_q),
		.inst_valid(inst_valid), .inst_data(inst_data), .inst_ready_q(inst_ready_q), .tx_valid_q(tx_valid_q),
		.tx_word_q(tx_word_q), .tx_ready(tx_ready), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));
	erf_link_model erf_link_model_inst (.clk(clk), .rst(rst), .slow(slow), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready));

	// Record taken words; offer the next instruction once one is taken.
	always @(posedge clk) begin
		if (tx_valid_q && tx_ready)
			q.push_back(tx_word_q);
		if (inst_valid && inst_ready_q) begin
			kk <= kk + 1;
			inst_data <= inst_of(kk + 1);
		end
	end

	task automatic tally_and_finish();
		if (n_fail == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 `CHK(reg_rdata_q, e);
	endtask

	// Sends one row's request and checks the whole frame that comes back.
	task automatic frame(input logic [38:0] row);
		logic [15:0] n;
		logic [15:0] w;
		logic [23:0] a;
		logic [23:0] b;
		int len;
		int sent;
		int k0;
		int i;
		n = row[31:16];
		len = (row[38:35] == 4'h2 && row[34:33] == 2'h0 && n <= 16'h8000) ? 3 * ((n + 1) / 2) + 2 : 2;
		// An odd read ends with a two word tail.
		sent = (len > 2 && n[0]) ? len - 1 : len;
		q.delete();
		k0 = kk;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= row[38:16];
		// Wait, bounded, until ready is seen settled after an edge; the next edge takes the request.
		#1;
		for (i = 0; i < 99 && req_ready_q !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (req_ready_q !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
		@(posedge clk);
		req_valid <= 1'b0;
		for (i = 0; i < 99 && q.size() < sent; i++)
			@(posedge clk);
		if (q.size() < sent) begin
			n_fail++;
			tally_and_finish();
		end
		repeat (4) @(posedge clk);
		`CHK(q.size(), sent);
		`CHK(q[0], row[15:0]);
		`CHK(q[1], len[15:0]);
		for (i = 0; len > 2 && 2 * i < n; i++) begin
			a = inst_of(k0 + 2 * i);
			b = inst_of(k0 + 2 * i + 1);
			w = (2 * i + 1 < n) ? {b[23:16], a[23:16]} : {8'h00, a[23:16]};
			`CHK(q[2 + 3 * i], a[15:0]);
			`CHK(q[3 + 3 * i], w);
			if (2 * i + 1 < n)
				`CHK(q[4 + 3 * i], b[15:0]);
		end
	endtask

	// Rows: command, outcome, blank, count, expected first header word.
	initial begin
		rows[0] = {4'h1, 2'h0, 1'h0, 16'h0000, 16'h1100};
		rows[1] = {4'hd, 2'h0, 1'h0, 16'h0000, 16'h1d00};
		rows[2] = {4'h4, 2'h1, 1'h0, 16'h0000, 16'h2401};
		rows[3] = {4'h5, 2'h1, 1'h0, 16'h0000, 16'h2501};
		rows[4] = {4'h5, 2'h2, 1'h0, 16'h0000, 16'h2502};
		rows[5] = {4'h1, 2'h1, 1'h0, 16'h0000, 16'h2102};
		rows[6] = {4'ha, 2'h0, 1'h1, 16'h0000, 16'h1af0};
		rows[7] = {4'ha, 2'h2, 1'h0, 16'h0000, 16'h1a0f};
		rows[8] = {4'hb, 2'h1, 1'h0, 16'h0000, 16'h1b10};
		rows[9] = {4'h3, 2'h0, 1'h0, 16'h0000, 16'h3302};
		rows[10] = {4'hf, 2'h0, 1'h0, 16'h0000, 16'h3f02};
		rows[11] = {4'h2, 2'h0, 1'h0, 16'h0000, 16'h1200};
		rows[12] = {4'h2, 2'h0, 1'h0, 16'h0001, 16'h1200};
		rows[13] = {4'h2, 2'h0, 1'h0, 16'h0004, 16'h1200};
		rows[14] = {4'h2, 2'h0, 1'h0, 16'h8001, 16'h2202};
		rows[15] = {4'h2, 2'h0, 1'h0, 16'h0003, 16'h1200};
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		inst_valid <= 1'b1;
		#1 `CHK(req_ready_q, 1'b0);
		// Reset values, a read-only count and an unmapped place.
		rd(4'h0, 16'h0001);
		rd(4'h1, 16'h0010);
		rd(4'h4, 16'h0000);
		rd(4'h5, 16'h0000);
		rd(4'hf, 16'h0000);
		wr(4'h3, 16'h1234);
		rd(4'h3, 16'h0000);
		// Every row, first with a prompt link, then with a stalling one.
		for (int s = 0; s < 2; s++) begin
			slow <= s[0];
			for (int r = 0; r < 16; r++)
				frame(rows[r]);
		end
		rd(4'h3, 16'h0020);
		wr(4'h1, 16'h0032);
		frame({4'hb, 2'h0, 1'h0, 16'h0000, 16'h1b32});
		// With the enable off a waiting request must not be answered.
		// Ready still stands one cycle after the disabling write, so offer only after it falls.
		wr(4'h0, 16'h0000);
		q.delete();
		@(posedge clk);
		req_valid <= 1'b1;
		req <= rows[0][38:16];
		repeat (6) @(posedge clk);
		`CHK(q.size(), 0);
		#1 `CHK(req_ready_q, 1'b0);
		req_valid <= 1'b0;
		wr(4'h0, 16'h0001);
		// Only the unknown-command event is let through the mask.
		wr(4'h4, 16'h0007);
		wr(4'h5, 16'h0004);
		frame(rows[0]);
		#1 `CHK(irq_q, 1'b0);
		frame(rows[9]);
		#1 `CHK(irq_q, 1'b1);
		rd(4'h4, 16'h0005);
		wr(4'h4, 16'h0004);
		repeat (2) @(posedge clk);
		#1 `CHK(irq_q, 1'b0);
		rd(4'h4, 16'h0001);
		// Idle status: last header high byte of the unknown-command frame, ready set, not busy.
		rd(4'h2, 16'h3302);
		tally_and_finish();
	end
endmodule
